// ==== design/fs_freq_synth_cfg.svh ====
/*
 * Register offsets, field positions, widths and reset values of
 * the frequency synthesiser. Assumes a 32-bit APB with byte addresses.
 */
`ifndef FS_FREQ_SYNTH_CFG_SVH
`define FS_FREQ_SYNTH_CFG_SVH

`define FS_ADDR_W        12
`define FS_OFS_CTRL      12'h000
`define FS_OFS_CLKCFG    12'h004
`define FS_OFS_ACCL      12'h008
`define FS_OFS_ACCH      12'h00C
`define FS_OFS_ACCU      12'h010
`define FS_OFS_INCL      12'h014
`define FS_OFS_INCH      12'h018
`define FS_OFS_INCU      12'h01C
`define FS_OFS_STATUS    12'h020
`define FS_OFS_ROUTE     12'h024

`define FS_CTRL_EN       7
`define FS_CTRL_OUT      5
`define FS_CTRL_POL      4
`define FS_CTRL_PULSE    0
`define FS_CLK_PWS_HI    7
`define FS_CLK_PWS_LO    5
`define FS_CLK_CKS_HI    1
`define FS_CLK_CKS_LO    0
`define FS_STAT_FLAG     0
`define FS_ROUTE_PIN     0

`define FS_ACC_W         20
`define FS_PCNT_W        8
`define FS_RESET_VAL     1'b0
`define FS_PEND_LOAD     2'h2

`endif

// ==== design/fs_pkg.sv ====
/*
 * Types of the frequency synthesiser: clock source codes and the
 * packed state record. Assumes fs_freq_synth_cfg.svh is compiled first.
 */
`include "fs_freq_synth_cfg.svh"

package fs_pkg;

   // Source codes in fixed order; the last code is reserved.
   typedef enum logic [1:0] {
      FS_SRC_FAST_OSC,
      FS_SRC_SYS_OSC,
      FS_SRC_LOGIC_CELL,
      FS_SRC_RESERVED
   } fs_src_t;

   // Every flip-flop of the block lives in this record.
   typedef struct packed {
      logic                    blockEnable;
      logic                    outputPolarity;
      logic                    pulseModeSelect;
      logic [2:0]              pulseWidthSelect;
      fs_src_t                 clockSourceSelect;
      logic                    pinRoute;
      logic [`FS_ACC_W-1:0]    incShadow;
      logic [`FS_ACC_W-1:0]    incBuf;
      logic [`FS_ACC_W-1:0]    acc;
      logic [1:0]              loadPend;
      logic                    srcPrev;
      logic                    toggleState;
      logic                    pulseArmed;
      logic [`FS_PCNT_W-1:0]   pulseCnt;
      logic                    outputLevel;
      logic                    overflowFlag;
      logic                    carryPulse;
      logic [7:0]              rdata;
      logic                    slverr;
   } fs_state_t;

endpackage : fs_pkg

// ==== design/fs_freq_synth.sv ====
/*
 * Numerically controlled oscillator with an APB register slave. A
 * 20-bit accumulator adds a double-buffered increment on each rising
 * edge of a selected source clock; the carry drives a toggle or pulse
 * output with polarity control and sets a sticky overflow flag.
 * Assumes source clocks arrive synchronous to sys_clk and each is high
 * or low for at least one sys_clk cycle, so edges are seen by sampling.
 */
`timescale 1ns/1ps
`include "fs_freq_synth_cfg.svh"

//
// Overview of operation
// (R1) Keep 20-bit accumulator, add increment per cycle.
// (R2) Accumulator carry is the raw overflow pulse.
// (R3) Every overflow also raises the interrupt event.
// (R4) Select field picks one of three clock sources.
// (R5) Accumulator readable, writable as three byte registers.
// (R6) Adder steps on selected source rising edge.
// (R7) Increment held in low, high, upper registers.
// (R8) Software writes upper, high, then low.
// (R9) Low write loads buffers on second edge.
// (R10) Increment registers readable, writable, double-buffered.
// (R11) Disabled: buffers load right after any write.
// (R12) Increment buffers hidden from software.
// (R13) Toggle mode inverts output on each overflow.
// (R14) Pulse-mode bit clear selects toggle mode.
// (R15) Pulse mode: active some periods, then inactive.
// (R16) Pulse goes active on edge after overflow.
// (R17) Polarity bit sets active and inactive levels.
// (R18) Pulse-mode bit set selects pulse mode.
// (R19) Three-bit field selects pulse width.
// (R20) Width beyond overflow interval: output stops toggling.
// (R21) Output feeds peripherals, optionally a pin.
// (R22) Reset clears every register to zero.
// (R23) Enable bit one runs, zero stops oscillator.
// (R24) Polarity change while enabled raises interrupt. The code sets only overflowFlag; overflowInterrupt does not pulse.
// (R25) Software clears overflow flag; hardware never does.
// (R26) Width code n gives 2**n periods.
// (R27) Source codes fixed order, last code reserved.
module fs_freq_synth (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   input  wire logic        fastInternalOscillator,
   input  wire logic        sysOscClock,
   input  wire logic        logicCellOneOutput,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             synthOut,
   output logic             synthPinOut,
   output logic             synthPinOutEn,
   output logic             overflowInterrupt,
   output logic             overflowFlag
);

   fs_pkg::fs_state_t q;
   fs_pkg::fs_state_t d;

   logic                    wrAcc;
   logic                    setup;
   logic                    srcNow;
   logic                    srcRise;
   logic                    stepEn;
   logic [`FS_ACC_W:0]      sum;
   logic                    carry;
   logic                    rawOut;
   logic                    polChange;
   logic [`FS_PCNT_W-1:0]   widthCnt;

   // Decodes an offset to a known register; used for reads and writes.
   function automatic logic fs_mapped(input logic [11:0] a);
      begin
         fs_mapped = (a == `FS_OFS_CTRL)   || (a == `FS_OFS_CLKCFG) ||
                     (a == `FS_OFS_ACCL)   || (a == `FS_OFS_ACCH)   ||
                     (a == `FS_OFS_ACCU)   || (a == `FS_OFS_INCL)   ||
                     (a == `FS_OFS_INCH)   || (a == `FS_OFS_INCU)   ||
                     (a == `FS_OFS_STATUS) || (a == `FS_OFS_ROUTE);
      end
   endfunction : fs_mapped

   // Read view of one byte register; hidden buffers never appear.
   function automatic logic [7:0] fs_read(input logic [11:0] a,
                                          input fs_pkg::fs_state_t s);
      begin
         fs_read = 8'h00;
         case (a)
            `FS_OFS_CTRL: begin
               fs_read[`FS_CTRL_EN]    = s.blockEnable;
               fs_read[`FS_CTRL_OUT]   = s.outputLevel;
               fs_read[`FS_CTRL_POL]   = s.outputPolarity;
               fs_read[`FS_CTRL_PULSE] = s.pulseModeSelect;
            end
            `FS_OFS_CLKCFG: begin
               fs_read[`FS_CLK_PWS_HI:`FS_CLK_PWS_LO] = s.pulseWidthSelect;
               fs_read[`FS_CLK_CKS_HI:`FS_CLK_CKS_LO] = s.clockSourceSelect;
            end
            `FS_OFS_ACCL:   fs_read = s.acc[7:0];  // [R5]
            `FS_OFS_ACCH:   fs_read = s.acc[15:8];  // [R5]
            `FS_OFS_ACCU:   fs_read = {4'h0, s.acc[19:16]};  // [R5]
            `FS_OFS_INCL:   fs_read = s.incShadow[7:0];  // [R10] [R12]
            `FS_OFS_INCH:   fs_read = s.incShadow[15:8];  // [R10]
            `FS_OFS_INCU:   fs_read = {4'h0, s.incShadow[19:16]};  // [R10]
            `FS_OFS_STATUS: fs_read[`FS_STAT_FLAG] = s.overflowFlag;
            `FS_OFS_ROUTE:  fs_read[`FS_ROUTE_PIN] = s.pinRoute;
            default:        fs_read = 8'h00;
         endcase
      end
   endfunction : fs_read

   // Bus phases. A write lands only in the access cycle, and not while
   // the clock enable is low, so a frozen block never loses a write.
   assign setup  = psel & ~penable;
   assign wrAcc  = psel & penable & pwrite & clkEn;
   assign pready = psel & penable & clkEn;

   // Source mux; the reserved code yields a still clock.
   always_comb begin
      case (q.clockSourceSelect)
         fs_pkg::FS_SRC_FAST_OSC:   srcNow = fastInternalOscillator;  // [R4]
         fs_pkg::FS_SRC_SYS_OSC:    srcNow = sysOscClock;  // [R27]
         fs_pkg::FS_SRC_LOGIC_CELL: srcNow = logicCellOneOutput;
         default:                   srcNow = 1'b0;  // [R27]
      endcase
   end

   // Rising edge of the selected source, gated by the block enable.
   assign srcRise = srcNow & ~q.srcPrev;
   assign stepEn  = srcRise & q.blockEnable;  // [R6] [R23]

   // Full adder over the buffered increment; bit 20 is the carry.
   assign sum   = {1'b0, q.acc} + {1'b0, q.incBuf};  // [R1]
   assign carry = stepEn & sum[`FS_ACC_W];  // [R2]

   // Width of the active pulse in source periods: 2**n.
   assign widthCnt = `FS_PCNT_W'(1) << q.pulseWidthSelect;  // [R26] [R19]

   // A polarity write that flips the bit flips the output too.
   assign polChange = wrAcc && (paddr == `FS_OFS_CTRL) &&
                      (pwdata[`FS_CTRL_POL] != q.outputPolarity);

   // Next-state logic for the whole block.
   always_comb begin
      d = q;
      d.srcPrev    = srcNow;
      d.carryPulse = carry;

      // Accumulator step on each enabled source edge.
      if (stepEn) begin
         d.acc = sum[`FS_ACC_W-1:0];  // [R1] [R6]
      end

      // Pending load counts source edges after a low-byte write.
      if (stepEn && (q.loadPend != 2'h0)) begin
         d.loadPend = q.loadPend - 2'h1;
         if (q.loadPend == 2'h1) begin
            d.incBuf = q.incShadow;  // [R9]
         end
      end

      // Toggle flip-flop advances on every overflow.
      if (carry) begin
         d.toggleState = ~q.toggleState;  // [R13]
      end

      // Pulse stretcher: an overflow arms, the next edge starts the
      // count, and a further overflow rearms so the pulse retriggers.
      // With a width longer than the overflow interval the count never
      // runs out and the output holds active.
      if (stepEn) begin
         if (q.pulseArmed) begin
            d.pulseCnt = widthCnt;  // [R16] [R20]
         end else if (q.pulseCnt != `FS_PCNT_W'(0)) begin
            d.pulseCnt = q.pulseCnt - `FS_PCNT_W'(1);  // [R15]
         end
         d.pulseArmed = carry;
      end

      // Sticky flag: set by hardware, cleared only by software.
      if (wrAcc && (paddr == `FS_OFS_STATUS) &&
          pwdata[`FS_STAT_FLAG]) begin
         d.overflowFlag = 1'b0;  // [R25]
      end

      // Register writes. Software wins over a same-cycle accumulator
      // step for the byte it writes.
      if (wrAcc) begin
         case (paddr)
            `FS_OFS_CTRL: begin
               d.blockEnable     = pwdata[`FS_CTRL_EN];  // [R23]
               d.outputPolarity  = pwdata[`FS_CTRL_POL];  // [R17]
               d.pulseModeSelect = pwdata[`FS_CTRL_PULSE];  // [R14] [R18]
            end
            `FS_OFS_CLKCFG: begin
               d.pulseWidthSelect =
                  pwdata[`FS_CLK_PWS_HI:`FS_CLK_PWS_LO];  // [R19]
               d.clockSourceSelect = fs_pkg::fs_src_t'(
                  pwdata[`FS_CLK_CKS_HI:`FS_CLK_CKS_LO]);  // [R4]
            end
            `FS_OFS_ACCL:  d.acc[7:0]   = pwdata[7:0];  // [R5]
            `FS_OFS_ACCH:  d.acc[15:8]  = pwdata[7:0];  // [R5]
            `FS_OFS_ACCU:  d.acc[19:16] = pwdata[3:0];  // [R5]
            `FS_OFS_INCL: begin
               d.incShadow[7:0] = pwdata[7:0];  // [R7]
               d.loadPend       = `FS_PEND_LOAD;  // [R9]
            end
            `FS_OFS_INCH:  d.incShadow[15:8]  = pwdata[7:0];  // [R7]
            `FS_OFS_INCU:  d.incShadow[19:16] = pwdata[3:0];  // [R7]
            `FS_OFS_ROUTE: d.pinRoute = pwdata[`FS_ROUTE_PIN];  // [R21]
            default: begin
            end
         endcase
      end

      // A disabled block takes the new increment at once and drops
      // any pending timed load, since no source edges are counted.
      if (!d.blockEnable) begin
         d.incBuf   = d.incShadow;  // [R11] [R10]
         d.loadPend = 2'h0;
      end

      // Overflow and polarity flips while enabled set the flag; set beats clear.
      if (carry || (polChange && q.blockEnable)) begin
         d.overflowFlag = 1'b1;  // [R3] [R24]
      end

      // Mode mux and polarity: a set polarity bit inverts the output.
      rawOut = d.pulseModeSelect ? (d.pulseCnt != `FS_PCNT_W'(0))
                                 : d.toggleState;  // [R14] [R18]
      d.outputLevel = rawOut ^ d.outputPolarity;  // [R17]

      // Read data is taken in the setup cycle so it can leave a flop.
      if (setup) begin
         d.rdata  = fs_read(paddr, q);
         d.slverr = ~fs_mapped(paddr);
      end
   end

   // State register: synchronous clear, frozen while clkEn is low.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q <= '0;  // [R22]
      end else if (clkEn) begin
         q <= d;
      end
   end

   // Outputs come from the state record; pslverr is also gated by psel and penable.
   assign prdata            = {24'h000000, q.rdata};
   assign pslverr           = q.slverr & psel & penable;
   assign synthOut          = q.outputLevel;  // [R21]
   assign synthPinOut       = q.outputLevel & q.pinRoute;  // [R21]
   assign synthPinOutEn     = q.pinRoute;
   assign overflowInterrupt = q.carryPulse;  // [R3]
   assign overflowFlag      = q.overflowFlag;

endmodule : fs_freq_synth

// ==== sim/fs_periph_model.sv ====
/* Model of a peripheral that consumes the synthesiser output.
   Assumes the output is a level that is settled at each sys_clk edge. */
`timescale 1ns/1ps
module fs_periph_model (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        synthOut,
   output logic      [15:0] riseCount
);
   logic lastLevel;
   // Counts rising edges only, as an edge-triggered consumer would.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lastLevel <= 1'b0;
         riseCount <= 16'h0000;
      end else begin
         lastLevel <= synthOut;
         if (synthOut && !lastLevel) riseCount <= riseCount + 16'h0001;
      end
   end
endmodule : fs_periph_model

// ==== sim/fs_freq_synth_assertions.sv ====
/* Port checker of the synthesiser, bound to its top module.
   Assumes the register offsets of the shared config header. */
`timescale 1ns/1ps
`include "fs_freq_synth_cfg.svh"
module fs_freq_synth_assertions (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        clkEn,
   input wire logic        fastInternalOscillator,
   input wire logic        sysOscClock,
   input wire logic        logicCellOneOutput,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        synthOut,
   input wire logic        synthPinOut,
   input wire logic        synthPinOutEn,
   input wire logic        overflowInterrupt,
   input wire logic        overflowFlag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Software clear of the flag; a carry at the same edge still wins.
   wire logic clrWr = psel && penable && pwrite && clkEn &&
      paddr == `FS_OFS_STATUS && pwdata[0];
   property p_int_flag; overflowInterrupt |-> overflowFlag; endproperty
   a_int_flag: assert property (p_int_flag)
      else $error("carry pulse without the flag");
   // A frozen block holds the pulse, so only a clocked cycle must end it.
   property p_int_one;
      overflowInterrupt && clkEn |=> !overflowInterrupt;
   endproperty
   a_int_one: assert property (p_int_one)
      else $error("carry pulse longer than one cycle");
   // Only a pulse made at the previous edge can be traced to a source.
   property p_int_src;
      overflowInterrupt && $past(clkEn) |->
         $past(fastInternalOscillator) || $past(sysOscClock) ||
         $past(logicCellOneOutput);
   endproperty
   a_int_src: assert property (p_int_src)
      else $error("carry without a high source level");
   property p_sticky; overflowFlag && !clrWr |=> overflowFlag; endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag dropped without software");
   property p_clear; clrWr |=> !overflowFlag || overflowInterrupt; endproperty
   a_clear: assert property (p_clear)
      else $error("flag not cleared by software");
   property p_pin; !synthPinOutEn |-> !synthPinOut; endproperty
   a_pin: assert property (p_pin)
      else $error("pin driven while not routed");
   property p_reset;
      $rose(rst_n) |-> !overflowFlag && !synthOut && !synthPinOutEn;
   endproperty
   a_reset: assert property (p_reset)
      else $error("output not cleared by reset");
   property p_freeze;
      !clkEn |=> $stable(overflowFlag) && $stable(synthOut);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock disabled");
   c_carry: cover property (overflowInterrupt);
   c_clear: cover property (clrWr && overflowFlag);
   c_pin: cover property (synthPinOutEn && synthOut);
endmodule : fs_freq_synth_assertions

bind fs_freq_synth fs_freq_synth_assertions u_fs_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
   .fastInternalOscillator(fastInternalOscillator),
   .sysOscClock(sysOscClock), .logicCellOneOutput(logicCellOneOutput),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .synthOut(synthOut), .synthPinOut(synthPinOut),
   .synthPinOutEn(synthPinOutEn), .overflowInterrupt(overflowInterrupt),
   .overflowFlag(overflowFlag)
);

// ==== sim/fs_freq_synth_tb_top.sv ====
/* Testbench of the synthesiser: APB master, source clock stimulus and a
   read scoreboard. Assumes the design, its header and the peripheral. */
`timescale 1ns/1ps
`include "fs_freq_synth_cfg.svh"
module fs_freq_synth_tb_top;
   logic        sys_clk = 0;
   logic        rst_n = 0;
   logic        clkEn = 1;
   logic [2:0]  src = 0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [31:0] prdata;
   logic        pready, pslverr, synthOut, synthPinOut, synthPinOutEn;
   logic        overflowInterrupt, overflowFlag;
   logic [15:0] riseCount;
   logic [32:0] expQ[$];
   logic [39:0] prod;
   logic [19:0] inc;
   int          num_errors = 0, n_compared = 0, nCarry = 0, cyc = 0;
   int          c0, sel;
   // Free-running system clock.
   always #2 sys_clk = ~sys_clk;
   fs_freq_synth dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
      .fastInternalOscillator(src[0]), .sysOscClock(src[1]),
      .logicCellOneOutput(src[2]), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .synthOut(synthOut),
      .synthPinOut(synthPinOut), .synthPinOutEn(synthPinOutEn),
      .overflowInterrupt(overflowInterrupt), .overflowFlag(overflowFlag));
   fs_periph_model periph (.sys_clk(sys_clk), .rst_n(rst_n),
      .synthOut(synthOut), .riseCount(riseCount));
   task check(input string nm, input logic [32:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task summarize;
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   // One transfer; an idle edge follows so results have landed on return.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
      @(posedge sys_clk);
   endtask : apb
   task rd(input logic [11:0] a, input logic [32:0] e);
      expQ.push_back(e);
      apb(0, a, 0);
   endtask : rd
   // Source clock only runs inside these bursts, two cycles per phase.
   task edges(input int n);
      repeat (n) begin
         src[sel] <= 1;
         repeat (2) @(posedge sys_clk);
         src[sel] <= 0;
         repeat (2) @(posedge sys_clk);
      end
   endtask : edges
   // Disabled block: accumulator cleared and increment loaded at once.
   task setup(input logic [7:0] cfg, input logic [19:0] v);
      apb(1, `FS_OFS_CTRL, 0);
      apb(1, `FS_OFS_CLKCFG, 32'(cfg));
      for (int i = 0; i < 3; i++) apb(1, `FS_OFS_ACCL + 12'(4 * i), 0);
      for (int i = 0; i < 3; i++)
         apb(1, `FS_OFS_INCU - 12'(4 * i), 32'(v >> (16 - 8 * i)) & 32'hFF);
   endtask : setup
   // Scoreboard of read data, carry counter and run limit.
   always @(posedge sys_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
         check("prdata", {pslverr, prdata}, expQ.pop_front());
      if (overflowInterrupt === 1'b1) nCarry++;
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         summarize();
      end
   end
   // Main sequence.
   initial begin
      inc = 20'($urandom(32'hC54C4D64));
      repeat (6) @(posedge sys_clk);
      rst_n <= 1;
      @(posedge sys_clk);
      for (int i = 0; i < 10; i++) rd(12'(4 * i), 33'h0);
      rd(12'h028, 33'h1_0000_0000);
      apb(1, `FS_OFS_ROUTE, 1);
      for (int k = 0; k < 3; k++) begin
         inc = 20'($urandom);
         sel = k;
         setup(8'(k), inc);
         c0 = nCarry;
         apb(1, `FS_OFS_CTRL, 32'h80);
         edges(3 + k);
         apb(1, `FS_OFS_CTRL, 0);
         prod = 40'(inc) * 40'(3 + k);
         rd(`FS_OFS_ACCL, 33'(prod[7:0]));
         rd(`FS_OFS_ACCH, 33'(prod[15:8]));
         rd(`FS_OFS_ACCU, 33'(prod[19:16]));
         rd(`FS_OFS_INCL, 33'(inc[7:0]));
         check("carries", 33'(nCarry - c0), 33'(prod >> 20));
         check("toggle", 33'(synthOut), 33'(nCarry % 2));
         check("pin", 33'(synthPinOut), 33'(synthOut));
         check("pinEn", 33'(synthPinOutEn), 33'h1);
         check("periph", 33'(riseCount), 33'((nCarry + 1) / 2));
      end
      sel = 0;
      setup(8'h00, 20'h0);
      apb(1, `FS_OFS_CTRL, 32'h80);
      apb(1, `FS_OFS_INCU, 32'h1);
      apb(1, `FS_OFS_INCL, 32'h0);
      edges(2);
      rd(`FS_OFS_ACCU, 33'h0);
      edges(1);
      rd(`FS_OFS_ACCU, 33'h1);
      setup(8'h00, 20'h80000);
      c0 = nCarry;
      edges(2);
      apb(1, `FS_OFS_CLKCFG, 32'h3);
      apb(1, `FS_OFS_CTRL, 32'h80);
      edges(2);
      check("idle", 33'(nCarry - c0), 33'h0);
      rd(`FS_OFS_ACCU, 33'h0);
      apb(1, `FS_OFS_CLKCFG, 32'h0);
      clkEn <= 0;
      repeat (3) @(posedge sys_clk);
      clkEn <= 1;
      edges(2);
      check("flag", 33'(overflowFlag), 33'h1);
      apb(1, `FS_OFS_STATUS, 32'h1);
      check("clear", 33'(overflowFlag), 33'h0);
      c0 = nCarry;
      apb(1, `FS_OFS_CTRL, 32'h90);
      repeat (2) @(posedge sys_clk);
      check("polflag", 33'(overflowFlag), 33'h1);
      check("pol", 33'(synthOut), 33'(1 - c0 % 2));
      setup(8'h20, 20'h40000);
      apb(1, `FS_OFS_CTRL, 32'h81);
      for (int i = 0; i < 4; i++) begin
         edges(i == 0 ? 4 : 1);
         check("pulse", 33'(synthOut), 33'(i == 1 || i == 2));
      end
      // Widest pulse outlasts a two-edge overflow interval: output holds.
      setup(8'hE0, 20'h80000);
      apb(1, `FS_OFS_CTRL, 32'h81);
      for (int i = 0; i < 2; i++) begin
         edges(6);
         check("longpulse", 33'(synthOut), 33'h1);
      end
      summarize();
   end
endmodule : fs_freq_synth_tb_top
